// ===== rtl/mes_status_regs.sv
// Motion event status bank with APB register slave and interrupt
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R1: Temperature byte, two's complement, zero is 23C
// R2: Flag set on trigger, zero when idle
// R3: Latch mode: permanent, timed, or non-latched
// R4: Flags report only when function enabled
// R5: Motion byte: flat..low-g, bit 7 down
// R6: Fifo byte: ready, watermark, full in 7..5
// R7: Software writes zero to reserved bits
// R8: Tap origin: sign bit 7, z y x
// R9: Slope origin: sign bit 3, z y x
// R10: Attitude bit 7 flat, needs flat enable
// R11: Attitude bit 6 z facing up/down
// R12: Attitude bits 5:4 x-y orientation code
// R13: Orientation bits ignore latch mode
// R14: Orientation holds while blocking condition active
// R15: Attitude high-g sign and axis bits
// R16: Five status registers are read-only
module mes_status_regs #(
  parameter int TEMP_LATCH_CYCLES = mes_pkg::TEMP_LATCH_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Detection engines, same clock
  input wire mes_pkg::mes_engine_t i_engine,
  input wire logic [7:0] i_temperature,
  // Interrupt level
  output logic o_irq
);
  import mes_pkg::*;

  // Refuse a hold span outside 1..1000000; zero would end every timed hold at once
  if (TEMP_LATCH_CYCLES < 1 || TEMP_LATCH_CYCLES > 1000000) begin : g_bad_span
    $error("TEMP_LATCH_CYCLES out of range");
  end

  // ***************************************************************
  // State
  // ***************************************************************
  logic [7:0] temperature_reading; // Chip temperature copy
  logic [10:0] flag; // Latched event flags
  logic [10:0] engine_q; // Previous enabled engine level, for edges
  logic [3:0] tap_origin; // Origin of last tap
  logic [3:0] slope_origin; // Origin of last slope
  logic [3:0] highg_origin; // Origin of last high-g
  logic flat_q; // Flat position
  logic [2:0] orient_q; // Live orientation code
  logic [1:0] latch_mode; // Software latch mode
  logic [10:0] event_enable; // Software enables
  logic [10:0] irq_status; // Sticky interrupt status
  logic [10:0] irq_mask; // Interrupt mask
  logic [31:0] timer; // Timed latch counter
  logic [10:0] trig; // Enabled engine levels
  logic [10:0] rise; // Enabled rising edges
  logic access; // APB access phase
  logic wr; // Write taken this cycle
  logic [9:0] idx; // Register index
  logic [10:0] w1c; // Status clear vector

  // ***************************************************************
  // Decode
  // ***************************************************************
  assign access = i_psel && i_penable;
  // Writes land only on the answering edge, so a wait state never repeats a clear
  assign wr = access && i_pwrite && o_pready;
  // Byte lane bits dropped; an unaligned address maps to its enclosing word
  assign idx = i_paddr[11:2];
  assign trig = i_engine.pulse & event_enable; // [R4]
  assign rise = trig & ~engine_q;
  assign w1c = (wr && idx == {2'h0, IDX_IRQ_STATUS}) ? i_pwdata[10:0] : 11'h000;

  // Software writes zero to reserved bits; they read zero anyway [R7]
  function automatic logic [7:0] fifo_byte(input logic [10:0] f);
    fifo_byte = {f[EV_DRDY], f[EV_WM], f[EV_FFULL], 5'h00};
  endfunction

  // ***************************************************************
  // Temperature copy, host cannot write it
  // ***************************************************************
  // Held in a flop so a read never sees a byte mid-change
  // Engine value passes straight through; zero means 23C [R1]
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      temperature_reading <= 8'h00;
    end else begin
      temperature_reading <= i_temperature;
    end
  end

  // ***************************************************************
  // Edge history of engine levels
  // ***************************************************************
  // Gated levels, so enabling a busy engine counts as a new edge
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      engine_q <= 11'h000;
    end else begin
      engine_q <= trig;
    end
  end

  // ***************************************************************
  // Timed latch counter, restarted by any new event
  // ***************************************************************
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      timer <= 32'h0;
    end else if (|rise) begin
      // Any fresh event restarts the full hold span
      timer <= 32'(TEMP_LATCH_CYCLES);
    end else if (timer != 32'h0) begin
      timer <= timer - 32'h1;
    end
  end

  // ***************************************************************
  // Event flags with latch mode
  // ***************************************************************
  // Non-latched follows the engine; timed holds until counter ends [R3]
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      flag <= 11'h000;
    end else begin
      case (latch_mode)
        LATCH_NONE: begin
          flag <= trig; // [R2]
        end
        LATCH_TEMP: begin
          // Idle or ending counter: fall back to the live level, so flags
          // carried over from permanent mode cannot stay set forever
          if (timer <= 32'h1 && ~|rise) begin
            flag <= trig; // [R3]
          end else begin
            flag <= flag | trig; // [R2]
          end
        end
        LATCH_PERM: begin
          flag <= flag | trig; // [R3]
        end
        default: begin
          flag <= trig;
        end
      endcase
    end
  end

  // ***************************************************************
  // Origin bytes, captured on each enabled trigger
  // ***************************************************************
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tap_origin <= 4'h0;
      slope_origin <= 4'h0;
      highg_origin <= 4'h0;
    end else begin
      // A held level keeps the origin; only a fresh enabled edge moves it
      if (rise[EV_STAP] || rise[EV_DTAP]) begin
        tap_origin <= i_engine.tap_origin; // [R8]
      end
      if (rise[EV_SLOPE]) begin
        slope_origin <= i_engine.slope_origin; // [R9]
      end
      if (rise[EV_HIGH]) begin
        highg_origin <= i_engine.highg_origin; // [R15]
      end
    end
  end

  // ***************************************************************
  // Attitude: live, no latching, orientation frozen while blocked
  // ***************************************************************
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      flat_q <= 1'b0;
      orient_q <= 3'h0;
    end else begin
      // Flat means nothing while its enable is off, so it reads zero
      flat_q <= i_engine.flat && event_enable[EV_FLAT]; // [R10]
      // Orientation ignores latching but freezes while blocked
      if (!i_engine.orient_block) begin
        orient_q <= i_engine.orient; // [R11] [R12] [R13] [R14]
      end
    end
  end

  // ***************************************************************
  // Own control registers and sticky interrupt status
  // ***************************************************************
  // Set wins over a clear in the same cycle
  // The status bank itself has no write path at all
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      latch_mode <= RST_LATCH_MODE;
      event_enable <= RST_EVENT_ENABLE;
      irq_mask <= RST_IRQ_MASK;
      irq_status <= 11'h000;
    end else begin
      irq_status <= (irq_status & ~w1c) | rise;
      if (wr && idx == {2'h0, IDX_LATCH_MODE}) begin
        latch_mode <= i_pwdata[1:0];
      end
      if (wr && idx == {2'h0, IDX_EVENT_ENABLE}) begin
        event_enable <= i_pwdata[10:0];
      end
      if (wr && idx == {2'h0, IDX_IRQ_MASK}) begin
        irq_mask <= i_pwdata[10:0];
      end
    end
  end

  // ***************************************************************
  // Interrupt output, registered
  // ***************************************************************
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      // Next status used, so the pin changes on the same edge as the status
      o_irq <= |(((irq_status & ~w1c) | rise) & irq_mask);
    end
  end

  // ***************************************************************
  // APB read and answer: one wait state, pready in cycle 2 of access
  // ***************************************************************
  // Read data taken at the access edge and stands with pready
  // Writes to the status bank are ignored without error [R16]
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= 32'h0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else if (access && !o_pready) begin
      o_pready <= 1'b1;
      o_pslverr <= 1'b0;
      case (idx)
        {2'h0, IDX_TEMPERATURE_READING}: o_prdata <= {24'h0, temperature_reading};
        {2'h0, IDX_MOTION_EVENT_STATUS}: o_prdata <= {24'h0, flag[7:0]}; // [R5]
        {2'h0, IDX_FIFO_EVENT_STATUS}: o_prdata <= {24'h0, fifo_byte(flag)}; // [R6]
        {2'h0, IDX_TAP_SLOPE_ORIGIN}: o_prdata <= {24'h0, tap_origin, slope_origin};
        {2'h0, IDX_ATTITUDE_HIGHG_STATUS}: begin
          o_prdata <= {24'h0, flat_q, orient_q, highg_origin};
        end
        {2'h0, IDX_LATCH_MODE}: o_prdata <= {30'h0, latch_mode};
        {2'h0, IDX_EVENT_ENABLE}: o_prdata <= {21'h0, event_enable};
        {2'h0, IDX_IRQ_STATUS}: o_prdata <= {21'h0, irq_status};
        {2'h0, IDX_IRQ_MASK}: o_prdata <= {21'h0, irq_mask};
        default: begin
          o_prdata <= 32'h0;
          o_pslverr <= 1'b1; // Unmapped address
        end
      endcase
    end else begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  sequence tap_rise_s;
    rise[EV_STAP] || rise[EV_DTAP];
  endsequence

  flag_follow_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R2]
    latch_mode == LATCH_NONE |=> flag == $past(trig))
    else $error("non-latched flag does not follow engine");
  perm_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R3]
    latch_mode == LATCH_PERM && $stable(latch_mode) |-> (($past(flag) & ~flag) == 11'h000))
    else $error("permanent flag dropped");
  enable_gate_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R4]
    latch_mode == LATCH_NONE && !event_enable[EV_LOW] |=> !flag[EV_LOW])
    else $error("disabled event reported");
  temp_copy_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R1]
    1'b1 |=> temperature_reading == $past(i_temperature))
    else $error("temperature not copied");
  tap_origin_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R8]
    tap_rise_s |=> tap_origin == $past(i_engine.tap_origin))
    else $error("tap origin not captured");
  slope_origin_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R9]
    rise[EV_SLOPE] |=> slope_origin == $past(i_engine.slope_origin))
    else $error("slope origin not captured");
  orient_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R14]
    i_engine.orient_block |=> $stable(orient_q))
    else $error("orientation moved while blocked");
  orient_live_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R13]
    !i_engine.orient_block |=> orient_q == $past(i_engine.orient))
    else $error("orientation not live");
  flat_gate_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R10]
    !event_enable[EV_FLAT] |=> !flat_q)
    else $error("flat shown while disabled");
  bank_ro_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R16]
    wr && idx == {2'h0, IDX_TAP_SLOPE_ORIGIN} && !(|rise) |=> $stable(tap_origin))
    else $error("status register written");
  highg_origin_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R15]
    rise[EV_HIGH] |=> highg_origin == $past(i_engine.highg_origin))
    else $error("high-g origin not captured");
  timed_expire_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R3]
    latch_mode == LATCH_TEMP && timer <= 32'h1 && rise == 11'h000 |=> flag == $past(trig))
    else $error("timed flag outlived its span");

  // ***************************************************************
  // Bus checks: one answer per transfer, writes on that edge only
  // ***************************************************************
  // Access phase seen while the answer is still pending
  sequence apb_take_s;
    access && !o_pready;
  endsequence

  // Answer stands one cycle, then drops before the next transfer
  sequence apb_done_s;
    o_pready ##1 !o_pready;
  endsequence

  pready_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    apb_take_s |=> apb_done_s)
    else $error("apb answer timing wrong");
  apb_error_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_pslverr |-> o_pready)
    else $error("error flag without answer");
  write_wait_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    apb_take_s ##0 (i_pwrite && idx == {2'h0, IDX_LATCH_MODE}) |=> $stable(latch_mode))
    else $error("write landed before the answer");
  mode_write_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    wr && idx == {2'h0, IDX_LATCH_MODE} |=> latch_mode == $past(i_pwdata[1:0]))
    else $error("latch mode write lost");

  // ***************************************************************
  // Read-back checks: each byte leaves in its bit layout, attitude in its orientation bits only
  // ***************************************************************
  temp_read_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R1]
    apb_take_s ##0 (idx == {2'h0, IDX_TEMPERATURE_READING}) |=>
      o_prdata == {24'h0, $past(temperature_reading)})
    else $error("temperature byte read wrong");
  motion_read_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R5]
    apb_take_s ##0 (idx == {2'h0, IDX_MOTION_EVENT_STATUS}) |=>
      o_prdata == {24'h0, $past(flag[7:0])})
    else $error("motion byte layout wrong");
  fifo_read_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R6]
    apb_take_s ##0 (idx == {2'h0, IDX_FIFO_EVENT_STATUS}) |=>
      o_prdata[7:5] == {$past(flag[EV_DRDY]), $past(flag[EV_WM]), $past(flag[EV_FFULL])}
      && o_prdata[4:0] == 5'h00)
    else $error("fifo byte layout wrong");
  origin_read_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R8]
    apb_take_s ##0 (idx == {2'h0, IDX_TAP_SLOPE_ORIGIN}) |=>
      o_prdata == {24'h0, $past(tap_origin), $past(slope_origin)})
    else $error("origin byte layout wrong");
  attitude_read_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R13]
    apb_take_s ##0 (idx == {2'h0, IDX_ATTITUDE_HIGHG_STATUS}) |=>
      o_prdata[6:4] == $past(orient_q))
    else $error("orientation bits read wrong");

  // ***************************************************************
  // Interrupt checks: sticky status, set wins, level follows mask
  // ***************************************************************
  irq_set_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    rise != 11'h000 |=> (irq_status & $past(rise)) == $past(rise))
    else $error("event lost from interrupt status");
  irq_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (|(irq_status & irq_mask)) && w1c == 11'h000 |=> o_irq)
    else $error("interrupt low with unmasked status");
  irq_idle_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    irq_status == 11'h000 && rise == 11'h000 |=> !o_irq)
    else $error("interrupt high with no status");

endmodule

`default_nettype wire

// ===== rtl/mes_pkg.sv
// Package: register map, field layout and timing for the motion event status bank
package mes_pkg;

  // ***************************************************************
  // Register offsets (printed offsets are not multiples of four,
  // so they are indices and the byte address is four times that)
  // ***************************************************************
  localparam logic [7:0] IDX_TEMPERATURE_READING = 8'h08;
  localparam logic [7:0] IDX_MOTION_EVENT_STATUS = 8'h09;
  localparam logic [7:0] IDX_FIFO_EVENT_STATUS = 8'h0a;
  localparam logic [7:0] IDX_TAP_SLOPE_ORIGIN = 8'h0b;
  localparam logic [7:0] IDX_ATTITUDE_HIGHG_STATUS = 8'h0c;
  // Own registers: latch mode, enables, interrupt status and mask
  localparam logic [7:0] IDX_LATCH_MODE = 8'h20;
  localparam logic [7:0] IDX_EVENT_ENABLE = 8'h21;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h22;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h23;

  // ***************************************************************
  // Field positions and widths
  // ***************************************************************
  localparam int NUM_EVENTS = 11;
  // Event vector order: bits 7..0 motion byte, 10..8 fifo byte
  localparam int EV_LOW = 0;
  localparam int EV_HIGH = 1;
  localparam int EV_SLOPE = 2;
  localparam int EV_NOMOT = 3;
  localparam int EV_DTAP = 4;
  localparam int EV_STAP = 5;
  localparam int EV_ORIENT = 6;
  localparam int EV_FLAT = 7;
  localparam int EV_FFULL = 8;
  localparam int EV_WM = 9;
  localparam int EV_DRDY = 10;
  localparam int FIFO_BYTE_LSB = 5;

  // ***************************************************************
  // Reset values and latch modes
  // ***************************************************************
  localparam logic [1:0] LATCH_NONE = 2'h0;
  localparam logic [1:0] LATCH_TEMP = 2'h1;
  localparam logic [1:0] LATCH_PERM = 2'h2;
  localparam logic [1:0] RST_LATCH_MODE = 2'h0;
  localparam logic [10:0] RST_EVENT_ENABLE = 11'h000;
  localparam logic [10:0] RST_IRQ_MASK = 11'h000;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_HZ = 25000000;
  localparam int TEMP_LATCH_US = 250;
  localparam int TEMP_LATCH_CYC = (TEMP_LATCH_US * (CLK_HZ / 1000000));

  // Engine inputs grouped together
  typedef struct packed {
    logic [10:0] pulse;   // Engine trigger levels, event order
    logic [3:0] tap_origin; // Sign, z, y, x
    logic [3:0] slope_origin;
    logic [3:0] highg_origin;
    logic flat;
    logic [2:0] orient;
    logic orient_block;
  } mes_engine_t;

endpackage

// ===== verification/mes_engine_model.sv
// Engine-side partner model feeding the status bank
`timescale 1ns/1ps
`default_nettype none
// ***************************************
// Clocked engine launch
// ***************************************
module mes_engine_model (
  input wire logic i_ref_clk,
  input wire mes_pkg::mes_engine_t i_req,
  output var mes_pkg::mes_engine_t o_engine
);
  import mes_pkg::*;
  // Real engines launch on the clock, so requests appear one edge late
  always_ff @(posedge i_ref_clk) begin
    o_engine <= i_req;
  end
endmodule
`default_nettype wire

// ===== verification/motion_event_status_regs_test.sv
// Register-level testbench for the motion event status bank
`timescale 1ns/1ps
`default_nettype none
module motion_event_status_regs_test;
  import mes_pkg::*;
  // ***************************************
  // Signals
  // ***************************************
  logic clk = 1'b0; // 25 MHz reference
  logic rst = 1'b1; // Async reset, high
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, irq, errv;
  logic [7:0] temp = 8'h00; // Raw temperature
  mes_engine_t req = '0; // Requested engine state
  mes_engine_t eng; // Engine outputs after the model
  int bad_count = 0, compares = 0;
  always #20 clk = ~clk;
  mes_engine_model mes_engine_model_inst (.i_ref_clk(clk), .i_req(req), .o_engine(eng));
  // Short timed latch keeps the run brief
  mes_status_regs #(.TEMP_LATCH_CYCLES(20)) mes_status_regs_inst (
    .i_ref_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_engine(eng),
    .i_temperature(temp), .o_irq(irq));
  // ***************************************
  // Tasks
  // ***************************************
  // Compare and count
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  // One APB transfer; the slave sets its pace, only the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    apb(1'b1, i, d);
  endtask
  task automatic rdc(input logic [7:0] i, input logic [31:0] e);
    apb(1'b0, i, 32'h0);
    check(rdv, e);
  endtask
  // Single-cycle engine trigger
  task automatic pulse(input logic [10:0] b);
    @(posedge clk);
    req.pulse <= b;
    @(posedge clk);
    req.pulse <= 11'h000;
  endtask
  task automatic close_out();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog sized well beyond the sequence below
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out();
  end
  // ***************************************
  // Sequence
  // ***************************************
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // Own registers after reset and an unmapped place
    rdc(IDX_LATCH_MODE, {30'h0, RST_LATCH_MODE});
    rdc(IDX_EVENT_ENABLE, {21'h0, RST_EVENT_ENABLE});
    rdc(IDX_IRQ_MASK, {21'h0, RST_IRQ_MASK});
    rdc(8'h3f, 32'h0);
    check({31'h0, errv}, 32'h1);
    $display("test reset done");
    // Temperature readout, negative value
    temp <= 8'hf6;
    rdc(IDX_TEMPERATURE_READING, 32'hf6);
    wr(IDX_TEMPERATURE_READING, 32'hff);
    rdc(IDX_TEMPERATURE_READING, 32'hf6);
    // Disabled function reports nothing
    req.pulse <= 11'h001;
    repeat (3) @(posedge clk);
    rdc(IDX_MOTION_EVENT_STATUS, 32'h0);
    req.pulse <= 11'h000;
    $display("test temp done");
    // Every event alone, non-latched, lands on its bit
    wr(IDX_EVENT_ENABLE, 32'h7ff);
    for (int i = 0; i < NUM_EVENTS; i++) begin
      req.pulse <= 11'(1 << i);
      repeat (3) @(posedge clk);
      rdc(IDX_MOTION_EVENT_STATUS, (i < 8) ? 32'(1 << i) : 32'h0);
      rdc(IDX_FIFO_EVENT_STATUS, (i < 8) ? 32'h0 : 32'(1 << (i - 3)));
    end
    req.pulse <= 11'h000;
    repeat (3) @(posedge clk);
    rdc(IDX_MOTION_EVENT_STATUS, 32'h0);
    $display("test events done");
    // Interrupt status, mask and clear
    rdc(IDX_IRQ_STATUS, 32'h7ff);
    check({31'h0, irq}, 32'h0);
    wr(IDX_IRQ_MASK, 32'h004);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h1);
    wr(IDX_IRQ_STATUS, 32'h7ff);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    rdc(IDX_IRQ_STATUS, 32'h0);
    $display("test irq done");
    // Permanent latch with origins
    wr(IDX_LATCH_MODE, {30'h0, LATCH_PERM});
    req.tap_origin <= 4'hd;
    req.slope_origin <= 4'ha;
    req.highg_origin <= 4'h9;
    pulse(11'h026);
    repeat (30) @(posedge clk);
    rdc(IDX_MOTION_EVENT_STATUS, 32'h26);
    rdc(IDX_TAP_SLOPE_ORIGIN, 32'hda);
    wr(IDX_TAP_SLOPE_ORIGIN, 32'h00);
    rdc(IDX_TAP_SLOPE_ORIGIN, 32'hda);
    rdc(IDX_ATTITUDE_HIGHG_STATUS, 32'h09);
    // Reserved bits kept zero; writes ignored
    wr(IDX_FIFO_EVENT_STATUS, 32'he0);
    rdc(IDX_FIFO_EVENT_STATUS, 32'h0);
    $display("test latch done");
    // Timed latch expires back to the idle engine
    wr(IDX_LATCH_MODE, {30'h0, LATCH_TEMP});
    pulse(11'h002);
    rdc(IDX_MOTION_EVENT_STATUS, 32'h02);
    repeat (30) @(posedge clk);
    rdc(IDX_MOTION_EVENT_STATUS, 32'h0);
    // Reserved mode code behaves as non-latched
    wr(IDX_LATCH_MODE, 32'h3);
    pulse(11'h004);
    rdc(IDX_MOTION_EVENT_STATUS, 32'h0);
    wr(IDX_LATCH_MODE, {30'h0, LATCH_PERM});
    $display("test timed done");
    // Flat needs its enable; orientation live under latching
    req.flat <= 1'b1;
    wr(IDX_EVENT_ENABLE, 32'h77f);
    rdc(IDX_ATTITUDE_HIGHG_STATUS, 32'h09);
    wr(IDX_EVENT_ENABLE, 32'h7ff);
    for (int o = 0; o < 8; o++) begin
      req.orient <= 3'(o);
      repeat (3) @(posedge clk);
      rdc(IDX_ATTITUDE_HIGHG_STATUS, {24'h0, 1'b1, 3'(o), 4'h9});
    end
    // Blocking freezes the last orientation
    req.orient_block <= 1'b1;
    req.orient <= 3'h2;
    repeat (3) @(posedge clk);
    rdc(IDX_ATTITUDE_HIGHG_STATUS, 32'hf9);
    req.orient_block <= 1'b0;
    repeat (3) @(posedge clk);
    rdc(IDX_ATTITUDE_HIGHG_STATUS, 32'ha9);
    $display("test attitude done");
    close_out();
  end
endmodule
`default_nettype wire
